// File: core/rtc_regs.svh
// Constants of the clock register file: offsets, field bits, reset values, timing
// Assumes a 50 MHz system clock; included by the register interface and by the bench
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH
// Byte addresses of the clock bytes at the top of the array
`define RTC_ADR_CTRL 13'h1ff8
`define RTC_ADR_SEC 13'h1ff9
`define RTC_ADR_MIN 13'h1ffa
`define RTC_ADR_HOUR 13'h1ffb
`define RTC_ADR_CENT 13'h1ffc
`define RTC_ADR_DATE 13'h1ffd
`define RTC_ADR_MON 13'h1ffe
`define RTC_ADR_YEAR 13'h1fff
// Field positions
`define RTC_B_LOAD 7
`define RTC_B_HALT 6
`define RTC_B_SIGN 5
`define RTC_B_OSC 7
`define RTC_B_FT 6
`define RTC_B_CEN 5
`define RTC_B_CF 4
`define RTC_B_BLE 7
`define RTC_B_BL 6
// Reset values; the oscillator leaves reset stopped
`define RTC_CTRL_RST 8'h00
`define RTC_SEC_RST 8'h80
`define RTC_ONE_RST 8'h01
// Timing: clock rate, one second, test tone
`define RTC_CLK_HZ 50000000
`define RTC_SEC_TIME_S 1
`define RTC_SEC_CYC (`RTC_CLK_HZ * `RTC_SEC_TIME_S)
`define RTC_FT_HZ 512
`define RTC_FT_HALF_CYC (`RTC_CLK_HZ / (2 * `RTC_FT_HZ))
`endif

// File: core/rtc_pkg.sv
// Types shared by the clock register block
// Assumes the constants header is available on the include path
`default_nettype none
package rtc_pkg;
  // Host bus state, one-hot
  typedef enum logic [2:0] {
    RTC_BUS_IDLE = 3'b001,
    RTC_BUS_READ = 3'b010,
    RTC_BUS_WRITE = 3'b100
  } rtc_bus_t;
endpackage
`default_nettype wire

// File: core/rtc_sync.sv
// Two-stage synchroniser for a group of asynchronous pins
// Assumes each bit is a slow level; multi-bit groups may skew by one cycle
`default_nettype none
module rtc_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // First stage, read only by the second stage
  logic [W-1:0] meta;

  // Two flops in series
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

// File: core/rtc_time_count.sv
// Running BCD time counters with calendar rollover and century flag
// Assumes one tick pulse per second and a load pulse from the register side
`default_nettype none
module rtc_time_count
  import rtc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic load,
  input wire logic [55:0] load_val,
  input wire logic load_cent,
  input wire logic cent_en,
  output logic [55:0] cnt,
  output logic cent
);
  // Packed fields: year,month,date,day,hour,minute,second
  logic [7:0] sec, min, hr, day, dat, mon, yr;
  logic [7:0] last_day;
  assign cnt = {yr, mon, dat, day, hr, min, sec};

  // BCD increment of one byte
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      return {v[7:4] + 4'h1, 4'h0};
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Last date of a month; leap years every fourth year only
  function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == 8'h02)
      return leap ? 8'h29 : 8'h28;
    if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
      return 8'h30;
    return 8'h31;
  endfunction

  assign last_day = month_end(mon, yr);

  // Counters advance on tick; load overrides
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      {yr, mon, dat, day, hr, min, sec} <= {8'h00, 8'h01, 8'h01, 8'h01, 24'h0};
      cent <= 1'b0;
    end
    else if (load)
    begin
      {yr, mon, dat, day, hr, min, sec} <= load_val;
      cent <= load_cent;
    end
    else if (tick)
    begin
      sec <= (sec == 8'h59) ? 8'h00 : bcd_inc(sec);
      if (sec == 8'h59)
      begin
        min <= (min == 8'h59) ? 8'h00 : bcd_inc(min);
        if (min == 8'h59)
        begin
          hr <= (hr == 8'h23) ? 8'h00 : bcd_inc(hr);
          if (hr == 8'h23)
          begin
            day <= (day == 8'h07) ? 8'h01 : bcd_inc(day);
            dat <= (dat == last_day) ? 8'h01 : bcd_inc(dat);
            if (dat == last_day)
            begin
              mon <= (mon == 8'h12) ? 8'h01 : bcd_inc(mon);
              if (mon == 8'h12)
              begin
                yr <= (yr == 8'h99) ? 8'h00 : bcd_inc(yr);
                // RQ19 century toggle
                if (yr == 8'h99 && cent_en)
                  cent <= ~cent;
              end
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: core/rtc_register_interface.sv
// Clock register file, static array and power-fail control behind async pins
// Assumes host pins are asynchronous and supply comparators give clean levels
//
// Summary of operation
// RQ1 - Host write: strobe and both selects active
// RQ2 - Select with strobe together keeps data floating
// RQ3 - Power fail deselects, blocks writes, floats outputs
// RQ4 - Failing write never touches other locations
// RQ5 - Below switch level run from battery
// RQ6 - Write protect until upper threshold reached
// RQ7 - Host halts updates before reading time
// RQ8 - Halt bit freezes register updates
// RQ9 - Halted registers hold time; counters keep running
// RQ10 - All registers update in one step
// RQ11 - Updates resume within one second
// RQ12 - Load bit halts updates for setting
// RQ13 - Clearing load bit copies registers to counters
// RQ14 - Time fields are 24-hour BCD
// RQ15 - Host writes zero to fixed-zero bits
// RQ16 - Oscillator stop bit; restart within second
// RQ17 - Oscillator stopped out of reset
// RQ18 - Battery low flag is read-only
// RQ19 - Century flag toggles only when enabled
// RQ20 - Century enable always writable
// RQ21 - Century flag writable only with load
// RQ22 - Calibration magnitude D4-D0, sign D5
// RQ23 - Test output toggles at 512 Hz
// RQ24 - Registers refresh once per second
`default_nettype none
`include "rtc_regs.svh"
module rtc_register_interface
  import rtc_pkg::*;
#(
  parameter int SEC_CYC = `RTC_SEC_CYC,
  parameter int FT_HALF_CYC = `RTC_FT_HALF_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [12:0] addr,
  input wire logic [7:0] data_pins_in,
  output logic [7:0] data_pins_out,
  output logic data_pins_oe,
  input wire logic chip_select_low_n,
  input wire logic chip_select_high,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic supply_above_threshold,
  input wire logic supply_above_switch,
  input wire logic battery_low_sense,
  output logic on_battery,
  output logic freq_test_out,
  output logic freq_test_oe
);
  // Synchronised pins
  logic [12:0] adr_s;
  logic [7:0] din_s;
  logic csl_n_s, csh_s, oe_n_s, we_n_s, pwr_ok, below_sw, bl_sense;
  // Bus control
  rtc_bus_t state;
  logic sel, wr_req, simul;
  logic [12:0] wadr;
  logic [7:0] wdat;
  logic commit;
  // Static array below the clock bytes
  logic [7:0] mem [0:8191];
  // Clock bytes
  logic [7:0] ctrl, sec_r, min_r, hr_r, cent_r, date_r, mon_r, yr_r;
  logic clk_wr, mem_we, halted, load_d, load_fall, upd;
  // Time base
  logic [31:0] presc;
  logic tick, tick_d;
  logic [55:0] cnt;
  logic cnt_cent;
  logic [31:0] ft_cnt;

  // All pins pass two flops; switch level enters inverted so reset reads as mains
  rtc_sync #(.W(28)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({addr, data_pins_in, chip_select_low_n, chip_select_high,
               output_enable_n, write_strobe_n, supply_above_threshold,
               ~supply_above_switch, battery_low_sense}),
    .sync_out({adr_s, din_s, csl_n_s, csh_s, oe_n_s, we_n_s, pwr_ok,
               below_sw, bl_sense})
  );

  // RQ3 deselect below threshold
  // RQ6 no access until upper threshold
  assign sel = ~csl_n_s & csh_s & pwr_ok;
  // RQ1 write needs strobe and both selects
  assign wr_req = sel & ~we_n_s;
  // Write takes effect at its end, and only with good supply
  // RQ4 abort write on power fail
  assign commit = (state == RTC_BUS_WRITE) & ~wr_req & pwr_ok;
  assign clk_wr = commit & (wadr >= `RTC_ADR_CTRL);
  assign mem_we = commit & (wadr < `RTC_ADR_CTRL);

  // Host bus sequencer
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= RTC_BUS_IDLE;
      simul <= 1'b0;
      wadr <= 13'h0;
      wdat <= 8'h00;
    end
    else
    begin
      // Capture from the first cycle the strobe is seen, so a short write keeps its address
      if (wr_req)
      begin
        wadr <= adr_s;
        wdat <= din_s;
      end
      unique case (state)
        RTC_BUS_IDLE:
        begin
          // RQ2 select and strobe together
          simul <= wr_req;
          if (wr_req)
            state <= RTC_BUS_WRITE;
          else if (sel)
            state <= RTC_BUS_READ;
        end
        RTC_BUS_READ:
        begin
          if (!sel)
          begin
            state <= RTC_BUS_IDLE;
            simul <= 1'b0;
          end
          else if (wr_req)
            state <= RTC_BUS_WRITE;
        end
        RTC_BUS_WRITE:
        begin
          // First release of strobe or select ends the write
          if (!wr_req && sel)
            state <= RTC_BUS_READ;
          else if (!wr_req)
          begin
            state <= RTC_BUS_IDLE;
            simul <= 1'b0;
          end
        end
      endcase
    end
  end

  // Array write; other locations are never touched by an aborted cycle
  always_ff @(posedge sys_clk)
  begin
    if (mem_we)
      mem[wadr] <= wdat;
  end

  // Read data and drive enable, registered
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      data_pins_out <= 8'h00;
      data_pins_oe <= 1'b0;
    end
    else
    begin
      // RQ2 float during simultaneous start
      // RQ3 float on power fail
      data_pins_oe <= (state == RTC_BUS_READ) & sel & we_n_s & ~oe_n_s & ~simul;
      unique case (adr_s)
        `RTC_ADR_CTRL: data_pins_out <= ctrl;
        `RTC_ADR_SEC: data_pins_out <= sec_r;
        `RTC_ADR_MIN: data_pins_out <= min_r;
        `RTC_ADR_HOUR: data_pins_out <= hr_r;
        `RTC_ADR_CENT: data_pins_out <= cent_r;
        // RQ18 flag comes from the monitor
        `RTC_ADR_DATE: data_pins_out <= {date_r[7], date_r[7] & bl_sense, date_r[5:0]};
        `RTC_ADR_MON: data_pins_out <= mon_r;
        `RTC_ADR_YEAR: data_pins_out <= yr_r;
        default: data_pins_out <= mem[adr_s];
      endcase
    end
  end

  // RQ8 halt bit freezes updates
  // RQ12 load bit freezes updates
  assign halted = ctrl[`RTC_B_HALT] | ctrl[`RTC_B_LOAD];
  // RQ13 load counters on falling load bit
  assign load_fall = load_d & ~ctrl[`RTC_B_LOAD];
  // RQ24 refresh each second unless halted
  assign upd = tick_d & ~halted;

  // Control byte; calibration bits stored only, the prescaler does not use them
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl <= `RTC_CTRL_RST;
      load_d <= 1'b0;
    end
    else
    begin
      load_d <= ctrl[`RTC_B_LOAD];
      // RQ22 sign and magnitude stored
      if (clk_wr && wadr == `RTC_ADR_CTRL)
        ctrl <= wdat;
    end
  end

  // Clock bytes: host write wins over a refresh of the same byte
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      // RQ17 oscillator stopped after reset
      sec_r <= `RTC_SEC_RST;
      {min_r, hr_r, yr_r} <= 24'h0;
      cent_r <= `RTC_ONE_RST;
      date_r <= `RTC_ONE_RST;
      mon_r <= `RTC_ONE_RST;
    end
    else
    begin
      // RQ10 one-step update
      // RQ9 registers frozen while halted
      if (upd)
      begin
        sec_r[6:0] <= cnt[6:0];
        min_r <= cnt[15:8];
        hr_r <= cnt[23:16];
        cent_r[2:0] <= cnt[26:24];
        cent_r[`RTC_B_CF] <= cnt_cent;
        date_r[5:0] <= cnt[37:32];
        mon_r <= cnt[47:40];
        yr_r <= cnt[55:48];
      end
      if (clk_wr)
      begin
        unique case (wadr)
          `RTC_ADR_SEC: sec_r <= wdat;
          `RTC_ADR_MIN: min_r <= wdat;
          `RTC_ADR_HOUR: hr_r <= wdat;
          `RTC_ADR_CENT:
          begin
            // RQ20 enable always writable
            cent_r[`RTC_B_CEN] <= wdat[`RTC_B_CEN];
            cent_r[7:6] <= wdat[7:6];
            cent_r[3:0] <= wdat[3:0];
            // RQ21 flag needs load bit
            if (ctrl[`RTC_B_LOAD])
              cent_r[`RTC_B_CF] <= wdat[`RTC_B_CF];
          end
          // RQ18 flag position not stored
          `RTC_ADR_DATE: date_r <= {wdat[7], 1'b0, wdat[5:0]};
          `RTC_ADR_MON: mon_r <= wdat;
          `RTC_ADR_YEAR: yr_r <= wdat;
          default: ;
        endcase
      end
    end
  end

  // One-second prescaler; held clear while the oscillator is stopped
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      presc <= 32'h0;
      tick <= 1'b0;
      tick_d <= 1'b0;
    end
    else
    begin
      tick_d <= tick;
      // RQ16 stop and restart oscillator
      // RQ11 next tick within one second
      if (sec_r[`RTC_B_OSC] || load_fall)
      begin
        presc <= 32'h0;
        tick <= 1'b0;
      end
      else if (presc == 32'(SEC_CYC - 1))
      begin
        presc <= 32'h0;
        tick <= 1'b1;
      end
      else
      begin
        presc <= presc + 32'h1;
        tick <= 1'b0;
      end
    end
  end

  // RQ14 counters run in BCD
  // RQ5 counting continues on battery
  rtc_time_count u_count (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick),
    .load(load_fall),
    .load_val({yr_r, 3'b000, mon_r[4:0], 2'b00, date_r[5:0], 5'h0, cent_r[2:0],
               2'b00, hr_r[5:0], 1'b0, min_r[6:0], 1'b0, sec_r[6:0]}),
    .load_cent(cent_r[`RTC_B_CF]),
    .cent_en(cent_r[`RTC_B_CEN]),
    .cnt(cnt),
    .cent(cnt_cent)
  );

  // Supply switch indication and test tone on an open-drain pin
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      on_battery <= 1'b0;
      freq_test_out <= 1'b0;
      freq_test_oe <= 1'b0;
      ft_cnt <= 32'h0;
    end
    else
    begin
      // RQ5 battery below switch level
      on_battery <= below_sw;
      freq_test_out <= 1'b0;
      // RQ23 512 Hz with oscillator running
      if (cent_r[`RTC_B_FT] && !sec_r[`RTC_B_OSC])
      begin
        if (ft_cnt == 32'(FT_HALF_CYC - 1))
        begin
          ft_cnt <= 32'h0;
          freq_test_oe <= ~freq_test_oe;
        end
        else
          ft_cnt <= ft_cnt + 32'h1;
      end
      else
      begin
        ft_cnt <= 32'h0;
        freq_test_oe <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_SIMUL_HIZ: assert property (simul |=> !data_pins_oe) // RQ2
    else $error("data driven after simultaneous select and strobe");
  AST_PFAIL_FLOAT: assert property (!pwr_ok |=> !data_pins_oe && state == RTC_BUS_IDLE) // RQ3
    else $error("outputs or bus active during power fail");
  AST_PFAIL_NOWR: assert property ((mem_we || clk_wr) |-> pwr_ok && wadr == $past(adr_s)) // RQ4
    else $error("write committed off supply or to a stale address");
  AST_BATT: assert property (below_sw |=> on_battery) // RQ5
    else $error("battery indication missing");
  AST_HALT_HOLD: assert property (halted && !clk_wr |=> $stable(min_r) && $stable(yr_r)) // RQ9
    else $error("clock bytes changed while halted");
  AST_LOAD: assert property (load_fall |=> cnt[6:0] == $past(sec_r[6:0])) // RQ13
    else $error("counters not loaded on load bit release");
  AST_OSC_STOP: assert property (sec_r[7] |=> presc == 32'h0 && !tick) // RQ16
    else $error("prescaler running with oscillator stopped");
  AST_CENT_WR: assert property (clk_wr && wadr == `RTC_ADR_CENT && !ctrl[7] && !upd
                                |=> $stable(cent_r[4])) // RQ21
    else $error("century flag written without load bit");
  AST_REFRESH: assert property (upd && !clk_wr |=> min_r == $past(cnt[15:8])) // RQ24
    else $error("minutes not refreshed from counter");
endmodule
`default_nettype wire

// File: test/rtc_host.sv
// Host processor model driving the async byte bus of the clock block
// Assumes two-flop pin sync in the device; write and idle phases held five cycles, reads up to twelve
`default_nettype none
module rtc_host (
  input wire logic sys_clk,
  input wire logic [7:0] q,
  input wire logic q_oe,
  output logic [12:0] addr,
  output logic [7:0] d,
  output logic cs_n,
  output logic cs,
  output logic oe_n,
  output logic we_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus starts deselected
  initial
  begin
    addr = 13'h0000;
    d = 8'h00;
    cs_n = 1'b1;
    cs = 1'b0;
    oe_n = 1'b1;
    we_n = 1'b1;
  end
  // Release; data flips so a stale value never looks driven
  task automatic idle();
    @(posedge sys_clk);
    cs_n <= 1'b1;
    cs <= 1'b0;
    oe_n <= 1'b1;
    we_n <= 1'b1;
    d <= ~d;
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] v,
    input logic oe, output logic saw);
    @(posedge sys_clk);
    addr <= a;
    d <= v;
    cs_n <= 1'b0;
    cs <= 1'b1;
    we_n <= 1'b0;
    oe_n <= ~oe;
    saw = 1'b0;
    // Note any drive while the strobe is held
    repeat (5)
    begin
      @(posedge sys_clk);
      saw = saw | q_oe;
    end
    // with output enable set, strobe ends first; selects and output enable stay
    if (oe)
    begin
      we_n <= 1'b1;
      repeat (5)
      begin
        @(posedge sys_clk);
        saw = saw | q_oe;
      end
    end
    idle();
  endtask
  // Read; bounded wait so a refused read cannot hang
  task automatic rd(input logic [12:0] a, output logic [7:0] v, output logic ok);
    @(posedge sys_clk);
    addr <= a;
    cs_n <= 1'b0;
    cs <= 1'b1;
    oe_n <= 1'b0;
    ok = 1'b0;
    v = 8'h00;
    for (int n = 0; n < 12 && !ok; n++)
    begin
      @(posedge sys_clk);
      ok = (q_oe === 1'b1);
      v = q;
    end
    idle();
  endtask
endmodule
`default_nettype wire

// File: test/rtc_register_interface_bench.sv
// Bench: host model, random RAM bytes, clock and power-fail behaviour
// Assumes short second and tone counts set through parameters
`default_nettype none
`include "rtc_regs.svh"
module rtc_register_interface_bench import rtc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SEC_C = 40; // One second, shortened for the run
  localparam int FT_H = 4; // Tone half period
  logic sys_clk;
  logic rst;
  logic [12:0] addr;
  logic [7:0] hd;
  logic [7:0] q;
  logic q_oe;
  logic cs_n;
  logic cs;
  logic oe_n;
  logic we_n;
  logic sup; // Supply above threshold
  logic sw; // Supply above switch level
  logic bat_low;
  logic on_bat;
  logic ft_out;
  logic ft_oe;
  int fails = 0;
  int checks_done = 0;
  logic [12:0] ra [8]; // Random RAM addresses
  logic [7:0] rv [8]; // Random RAM data
  // Time set just before a century rollover, and what follows it
  logic [7:0] tv [8] = '{8'h80, 8'h59, 8'h59, 8'h23, 8'h21, 8'h31, 8'h12, 8'h99};
  logic [7:0] ev [8] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
  rtc_register_interface #(.SEC_CYC(SEC_C), .FT_HALF_CYC(FT_H)) i_rtc_register_interface (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .data_pins_in(hd),
    .data_pins_out(q), .data_pins_oe(q_oe), .chip_select_low_n(cs_n),
    .chip_select_high(cs), .output_enable_n(oe_n), .write_strobe_n(we_n),
    .supply_above_threshold(sup), .supply_above_switch(sw),
    .battery_low_sense(bat_low), .on_battery(on_bat),
    .freq_test_out(ft_out), .freq_test_oe(ft_oe));
  rtc_host i_rtc_host (
    .sys_clk(sys_clk), .q(q), .q_oe(q_oe), .addr(addr), .d(hd),
    .cs_n(cs_n), .cs(cs), .oe_n(oe_n), .we_n(we_n));
  // 50 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Byte compare
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Flag compare
  task automatic chk1(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Read a byte and compare it
  task automatic rc(input logic [12:0] a, input logic [7:0] e, input string nm);
    logic [7:0] v;
    logic ok;
    i_rtc_host.rd(a, v, ok);
    chk1(nm, 1'b1, ok);
    chk8(nm, e, v);
  endtask
  // Plain write
  task automatic w(input logic [12:0] a, input logic [7:0] v);
    logic s;
    i_rtc_host.wr(a, v, 1'b0, s);
  endtask
  // Clock byte values after reset
  function automatic logic [7:0] exp_rst(input int i);
    if (i == 1)
      return `RTC_SEC_RST;
    return (i >= 4 && i <= 6) ? `RTC_ONE_RST : 8'h00;
  endfunction
  // Century byte after rollover: flag flips when enabled, weekday wraps 7 to 1
  function automatic logic [7:0] roll_cent(input logic [7:0] b);
    return {b[7:5], b[4] ^ b[5], b[3], (b[2:0] == 3'h7) ? 3'h1 : b[2:0] + 3'h1};
  endfunction
  // Cycles between two tone edges, bounded
  task automatic half_period(output int c);
    logic l;
    l = ft_oe;
    for (int n = 0; n < 20 && ft_oe === l; n++)
      @(posedge sys_clk);
    l = ft_oe;
    c = 0;
    while (ft_oe === l && c < 20)
    begin
      @(posedge sys_clk);
      c++;
    end
  endtask
  // Watchdog: the run needs well under two thousand cycles
  initial
  begin
    #(20 * 40000);
    fails++;
    close_out();
  end
  // Main sequence
  initial
  begin
    logic [7:0] v;
    logic ok;
    logic s;
    int n;
    rst = 1'b1;
    sup = 1'b1;
    sw = 1'b1;
    bat_low = 1'b0;
    void'($urandom(32'h5c89));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++)
      rc(`RTC_ADR_CTRL + 13'(i), exp_rst(i), "reset value");
    $display("test reset values done");
    for (int i = 0; i < 8; i++)
    begin
      ra[i] = 13'(i * 1024 + $urandom_range(1000));
      rv[i] = 8'($urandom);
      w(ra[i], rv[i]);
    end
    for (int i = 0; i < 8; i++)
      rc(ra[i], rv[i], "ram byte");
    $display("test ram done");
    for (int i = 0; i < 8; i++)
      w(`RTC_ADR_CTRL + 13'(i), tv[i]);
    w(`RTC_ADR_CTRL, 8'h00);
    repeat (50) @(posedge sys_clk);
    w(`RTC_ADR_CTRL, 8'h40);
    for (int i = 0; i < 8; i++)
      rc(`RTC_ADR_CTRL + 13'(i), (i == 4) ? roll_cent(tv[4]) : ev[i], "rollover");
    repeat (100) @(posedge sys_clk);
    rc(`RTC_ADR_SEC, 8'h00, "held seconds");
    w(`RTC_ADR_CTRL, 8'h00);
    repeat (45) @(posedge sys_clk);
    w(`RTC_ADR_CTRL, 8'h40);
    i_rtc_host.rd(`RTC_ADR_SEC, v, ok);
    chk1("seconds ran on", 1'b1, ok && v >= 8'h03);
    $display("test set and halt done");
    w(`RTC_ADR_CTRL, 8'h7f);
    rc(`RTC_ADR_CTRL, 8'h7f, "calibration");
    w(`RTC_ADR_CENT, 8'h02);
    rc(`RTC_ADR_CENT, 8'h12, "century no load");
    w(`RTC_ADR_CTRL, 8'h80);
    w(`RTC_ADR_CENT, 8'h02);
    rc(`RTC_ADR_CENT, 8'h02, "century load");
    bat_low <= 1'b1;
    w(`RTC_ADR_DATE, 8'hc1);
    rc(`RTC_ADR_DATE, 8'hc1, "low flag on");
    w(`RTC_ADR_DATE, 8'h41);
    rc(`RTC_ADR_DATE, 8'h01, "low flag write");
    bat_low <= 1'b0;
    $display("test flags done");
    w(`RTC_ADR_SEC, 8'h85);
    w(`RTC_ADR_CTRL, 8'h00);
    repeat (100) @(posedge sys_clk);
    w(`RTC_ADR_CTRL, 8'h40);
    rc(`RTC_ADR_SEC, 8'h85, "stopped");
    w(`RTC_ADR_CTRL, 8'h80);
    w(`RTC_ADR_SEC, 8'h05);
    w(`RTC_ADR_CTRL, 8'h00);
    repeat (50) @(posedge sys_clk);
    w(`RTC_ADR_CTRL, 8'h40);
    rc(`RTC_ADR_SEC, 8'h06, "restarted");
    w(`RTC_ADR_CENT, 8'h42);
    half_period(n);
    chk8("tone half period", 8'(FT_H), 8'(n));
    chk1("tone data", 1'b0, ft_out);
    w(`RTC_ADR_CENT, 8'h02);
    $display("test oscillator done");
    sup <= 1'b0;
    repeat (5) @(posedge sys_clk);
    i_rtc_host.rd(ra[0], v, ok);
    chk1("read in fail", 1'b0, ok);
    w(ra[0], ~rv[0]);
    sw <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk1("on battery", 1'b1, on_bat);
    sw <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk1("off battery", 1'b0, on_bat);
    sup <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rc(ra[0], rv[0], "protected");
    fork
      i_rtc_host.wr(ra[1], 8'h00, 1'b0, s);
      begin
        repeat (3) @(posedge sys_clk);
        sup <= 1'b0;
      end
    join
    sup <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rc(ra[2], rv[2], "neighbour");
    i_rtc_host.wr(ra[3], 8'h5a, 1'b1, s);
    chk1("drive in write", 1'b0, s);
    rc(ra[3], 8'h5a, "write with oe");
    $display("test power and bus done");
    close_out();
  end
endmodule
`default_nettype wire
